// File: pkg/load_fault_monitor_regs.vh
// Constants for the load fault monitor
`ifndef LOAD_FAULT_MONITOR_REGS_VH
`define LOAD_FAULT_MONITOR_REGS_VH
`define LFM_CHANNELS       8
`define LFM_CLK_MHZ        125
`define LFM_FILTER_MIN_US  100
`define LFM_FILTER_MAX_US  300
// Chosen filter interval, inside the allowed range
`define LFM_FILTER_US      200
`define LFM_FILTER_CYCLES  (`LFM_FILTER_US * `LFM_CLK_MHZ)
`define LFM_STATUS_RESET   8'h00
`define LFM_MSB            7
`endif

// File: hw/load_fault_monitor.v
// Fault detection, latching and serial status shifting for eight channels
// What this block does
// - Check open load only while the channel's command bit is low.
// - Each channel has its own independent open-load result.
// - Open load declared when drain-source comparison is below threshold.
// - Chip-select rising edge starts delay; open-load ignored until expiry.
// - Detected fault stays latched in status until read.
// - Channel resumes normal operation when open load disappears.
// - Thermal event turns off only the affected channel.
// - Thermally off channel retries automatically when flag clears.
// - Short fault from short-to-supply or current-limit indication.
// - Logic-supply undervoltage turns all outputs off, clears status.
// - After undervoltage release, status capture resumes normally.
// - Load-supply undervoltage neither turns outputs off nor resets.
// - Faulted channel reports one, healthy channel reports zero.
// - Status shifted out channel eight first, MSB first.
// - Fault detection active only while enable high; latched status still shifts out while low.
`timescale 1ns/1ps
`include "load_fault_monitor_regs.vh"
module load_fault_monitor #(
	parameter N = `LFM_CHANNELS,
	parameter FILTER_CYCLES = `LFM_FILTER_CYCLES
)(
	// Clock and reset
	input  wire         clk,
	input  wire         rst_n,
	// Serial link pins
	input  wire         cs_n,
	input  wire         sclk,
	input  wire         serial_command_in,
	output reg          serial_status_out,
	output wire         serial_status_out_en_n,
	// Control pins
	input  wire         enable,
	input  wire         logic_supply_uv,
	input  wire         load_supply_uv,
	input  wire         direct_drive_five,
	input  wire         direct_drive_six,
	// Comparator flags per channel
	input  wire [N-1:0] open_load_threshold,
	input  wire [N-1:0] short_to_supply,
	input  wire [N-1:0] current_limit,
	input  wire [N-1:0] over_temp,
	// Outputs
	output reg  [N-1:0] gate_drive,
	output reg  [N-1:0] command_word,
	output reg  [N-1:0] fault_status_register
);
	// Two-stage synchronisers for all async inputs
	reg  [2:0] s1_link;
	reg  [2:0] s2_link;
	reg  [2:0] s1_ctl;
	reg  [2:0] s2_ctl;
	reg  [N-1:0] s1_ol;
	reg  [N-1:0] s2_ol;
	reg  [N-1:0] s1_sh;
	reg  [N-1:0] s2_sh;
	reg  [N-1:0] s1_ot;
	reg  [N-1:0] s2_ot;
	reg  [1:0]   s1_dd;
	reg  [1:0]   s2_dd;
	reg          sclk_d;
	reg          cs_d;
	reg  [N-1:0] shift_in;
	reg  [N-1:0] shift_out;
	reg  [31:0]  timer;
	reg          armed;
	wire         cs_s;
	wire         sclk_s;
	wire         din_s;
	wire         en_s;
	wire         luv_s;
	wire         sclk_rise;
	wire         cs_rise;
	wire         cs_fall;
	wire [N-1:0] cmd_eff;
	wire [N-1:0] open_fault;
	wire [N-1:0] short_fault;
	wire [N-1:0] live_fault;
	reg  [N-1:0] s1_cl;
	reg  [N-1:0] s2_cl;
	wire [N-1:0] current_lim_s;
	assign cs_s   = s2_link[0];
	assign sclk_s = s2_link[1];
	assign din_s  = s2_link[2];
	assign en_s   = s2_ctl[0];
	assign luv_s  = s2_ctl[1];
	assign sclk_rise = sclk_s & ~sclk_d;
	assign cs_rise   = cs_s & ~cs_d;
	assign cs_fall   = ~cs_s & cs_d;
	assign serial_status_out_en_n = cs_s;
	// Direct drive pins OR into channels five and six
	assign cmd_eff = command_word | ({{(N-6){1'b0}}, s2_dd, 4'h0});
	assign open_fault = {N{armed & en_s}} & ~cmd_eff & ~s2_ol;
	// short or over-temperature while on
	assign short_fault = {N{en_s}} & cmd_eff & (s2_sh | s2_ot);
	assign live_fault = open_fault | short_fault |
		({N{en_s}} & cmd_eff & s2_sh) | ({N{en_s}} & current_lim_s);
	assign current_lim_s = cmd_eff & s2_cl;
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_link <= 3'h1;
			s2_link <= 3'h1;
			s1_ctl  <= 3'h4;
			s2_ctl  <= 3'h4;
			s1_ol   <= {N{1'b1}};
			s2_ol   <= {N{1'b1}};
			s1_sh   <= {N{1'b0}};
			s2_sh   <= {N{1'b0}};
			s1_cl   <= {N{1'b0}};
			s2_cl   <= {N{1'b0}};
			s1_ot   <= {N{1'b0}};
			s2_ot   <= {N{1'b0}};
			s1_dd   <= 2'h0;
			s2_dd   <= 2'h0;
			sclk_d  <= 1'b0;
			cs_d    <= 1'b1;
		end
		else
		begin
			s1_link <= {serial_command_in, sclk, cs_n};
			s2_link <= s1_link;
			s1_ctl  <= {load_supply_uv, logic_supply_uv, enable};
			s2_ctl  <= s1_ctl;
			s1_ol   <= open_load_threshold;
			s2_ol   <= s1_ol;
			s1_sh   <= short_to_supply;
			s2_sh   <= s1_sh;
			s1_cl   <= current_limit;
			s2_cl   <= s1_cl;
			s1_ot   <= over_temp;
			s2_ot   <= s1_ot;
			s1_dd   <= {direct_drive_six, direct_drive_five};
			s2_dd   <= s1_dd;
			sclk_d  <= sclk_s;
			cs_d    <= cs_s;
		end
	end
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			timer <= 32'h0;
			armed <= 1'b0;
		end
		else if (luv_s)
		begin
			timer <= 32'h0;
			armed <= 1'b0;
		end
		else if (cs_rise)
		begin
			timer <= 32'h0;
			armed <= 1'b0;
		end
		else if (!armed)
		begin
			if (timer == FILTER_CYCLES - 1)
				armed <= 1'b1;
			else
				timer <= timer + 32'h1;
		end
	end
	// Serial shift, command load and status latching
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shift_in <= {N{1'b0}};
			shift_out <= {N{1'b0}};
			serial_status_out <= 1'b0;
			command_word <= {N{1'b0}};
			fault_status_register <= `LFM_STATUS_RESET;
		end
		// clear status and command on logic undervoltage
		else if (luv_s)
		begin
			shift_in <= {N{1'b0}};
			shift_out <= {N{1'b0}};
			serial_status_out <= 1'b0;
			command_word <= {N{1'b0}};
			fault_status_register <= `LFM_STATUS_RESET;
		end
		else
		begin
			if (cs_fall)
			begin
				// clear on transfer unless still faulted
				shift_out <= fault_status_register | live_fault;
				fault_status_register <= live_fault;
			end
			else
				fault_status_register <= fault_status_register | live_fault;
			if (!cs_s && sclk_rise)
			begin
				serial_status_out <= shift_out[N-1];
				shift_out <= {shift_out[N-2:0], shift_in[N-1]};
				shift_in <= {shift_in[N-2:0], din_s};
			end
			if (cs_rise)
				command_word <= shift_in;
		end
	end
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			gate_drive <= {N{1'b0}};
		else if (luv_s || !en_s)
			gate_drive <= {N{1'b0}};
		else
			gate_drive <= cmd_eff & ~s2_ot;
	end
endmodule

// File: testbench/lfm_host.sv
// Serial link master standing in for the controller
`timescale 1ns/1ps
module lfm_host (
	// Link pins
	output reg  cs_n,
	output reg  sclk,
	output reg  sdi,
	input  wire sdo
);
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
	end
	// One 8-bit frame, 64 ns link clock, clock idle low
	task xfer(input [7:0] tx, output [7:0] rx);
		integer i;
		begin
			sdi = tx[7];
			cs_n = 1'b0;
			#32;
			for (i = 7; i >= 0; i = i - 1)
			begin
				sclk = 1'b1;
				#32 sclk = 1'b0;
				sdi = (i > 0) ? tx[(i+7)%8] : ~tx[0];
				#28 rx[i] = sdo;
				#4;
			end
			cs_n = 1'b1;
			#8;
		end
	endtask
endmodule

// File: testbench/load_fault_monitor_asserts.sv
// Assertion checker for the load fault monitor
`timescale 1ns/1ps
module lfm_chk (
	// Clock and reset
	input wire       clk,
	input wire       rst_n,
	// Inputs
	input wire       cs_n,
	input wire       enable,
	input wire       logic_supply_uv,
	input wire [7:0] over_temp,
	input wire [7:0] short_to_supply,
	// Outputs
	input wire       serial_status_out_en_n,
	input wire [7:0] gate_drive,
	input wire [7:0] command_word,
	input wire [7:0] fault_status_register
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire ok = enable && !logic_supply_uv;
	wire [7:0] fsr = fault_status_register;
	property p_uv; logic_supply_uv[*4] |-> gate_drive == 8'h00
		&& fsr == 8'h00; endproperty
	property p_en; !enable[*4] |-> gate_drive == 8'h00; endproperty
	property p_ot; $stable(over_temp)[*4] |->
		(gate_drive & over_temp) == 8'h00; endproperty
	property p_drv; (ok && over_temp == 8'h00 && $stable(command_word))[*4]
		|-> gate_drive[3:0] == command_word[3:0]; endproperty
	property p_cmd; (cs_n && !logic_supply_uv)[*6] |->
		$stable(command_word); endproperty
	property p_oe; cs_n[*3] |-> serial_status_out_en_n; endproperty
	property p_short; (short_to_supply[7] && command_word[7] && ok)[*4]
		|-> fsr[7]; endproperty
	property p_latch; (cs_n && ok)[*4] |->
		(fsr & $past(fsr)) == $past(fsr); endproperty
	a_uv: assert property (p_uv) else $error("uv not off");
	a_en: assert property (p_en) else $error("drive while off");
	a_ot: assert property (p_ot) else $error("hot ch on");
	a_drv: assert property (p_drv) else $error("drive mismatch");
	a_cmd: assert property (p_cmd) else $error("cmd moved");
	a_oe: assert property (p_oe) else $error("out driven idle");
	a_short: assert property (p_short) else $error("short lost");
	a_latch: assert property (p_latch) else $error("fault lost");
	c_ot: cover property (over_temp[0] ##1 !over_temp[0]);
	c_frame: cover property (!cs_n[*8]);
	c_uv: cover property (logic_supply_uv[*4]);
endmodule

// File: testbench/load_fault_monitor_tb.sv
// Testbench for the load fault monitor
`timescale 1ns/1ps
module load_fault_monitor_tb;
	localparam F = 20;
	reg        clk = 1'b0, rst_n = 1'b0, enable = 1'b1;
	reg        logic_supply_uv = 1'b0, load_supply_uv = 1'b0;
	reg        direct_drive_five = 1'b0, direct_drive_six = 1'b0;
	reg  [7:0] open_load_threshold = 8'hff, over_temp = 8'h00;
	reg  [7:0] short_to_supply = 8'h00, current_limit = 8'h00, rx;
	wire       cs_n, sclk, serial_command_in;
	wire       serial_status_out, serial_status_out_en_n;
	wire [7:0] gate_drive, command_word, fault_status_register;
	integer    fail_count = 0, total_checks = 0;
	always #4 clk = ~clk;
	load_fault_monitor #(.FILTER_CYCLES(F)) dut_u (
		.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
		.serial_command_in(serial_command_in),
		.serial_status_out(serial_status_out),
		.serial_status_out_en_n(serial_status_out_en_n),
		.enable(enable), .logic_supply_uv(logic_supply_uv),
		.load_supply_uv(load_supply_uv),
		.direct_drive_five(direct_drive_five),
		.direct_drive_six(direct_drive_six),
		.open_load_threshold(open_load_threshold),
		.short_to_supply(short_to_supply), .current_limit(current_limit),
		.over_temp(over_temp), .gate_drive(gate_drive),
		.command_word(command_word),
		.fault_status_register(fault_status_register));
	lfm_host m_u (.cs_n(cs_n), .sclk(sclk), .sdi(serial_command_in),
		.sdo(serial_status_out));
	task chk(input [7:0] got, input [7:0] exp);
	begin
		total_checks = total_checks + 1;
		if (got !== exp)
		begin
			fail_count = fail_count + 1;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task cyc(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task give_verdict;
	begin
		$display("checks %0d fails %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		#100000 fail_count = fail_count + 1;
		give_verdict;
	end
	initial
	begin
		cyc(3);
		rst_n = 1'b1;
		cyc(3);
		chk(gate_drive, 8'h00);
		load_supply_uv = 1'b1;
		direct_drive_five = 1'b1;
		m_u.xfer(8'h03, rx);
		cyc(6);
		chk(command_word, 8'h03);
		chk(gate_drive, 8'h13);
		direct_drive_five = 1'b0;
		over_temp = 8'h01;
		cyc(5);
		chk(gate_drive, 8'h02);
		over_temp = 8'h00;
		cyc(5);
		chk(gate_drive, 8'h03);
		open_load_threshold = 8'hfe;
		m_u.xfer(8'h00, rx);
		chk(rx, 8'h01);
		cyc(F / 2);
		chk(fault_status_register, 8'h00);
		// Wait out the filter before reading
		cyc(F + 5);
		chk(fault_status_register, 8'h01);
		open_load_threshold = 8'hfd;
		cyc(F);
		m_u.xfer(8'h02, rx);
		chk(rx, 8'h03);
		cyc(F + 5);
		m_u.xfer(8'h86, rx);
		chk(rx, 8'h02);
		short_to_supply = 8'h80;
		current_limit = 8'h04;
		cyc(F + 5);
		m_u.xfer(8'h02, rx);
		chk(rx, 8'h84);
		chk({7'h00, rx[1]}, 8'h00);
		short_to_supply = 8'h00;
		current_limit = 8'h00;
		open_load_threshold = 8'hff;
		cyc(F + 5);
		m_u.xfer(8'h02, rx);
		chk(rx, 8'h84);
		cyc(5);
		enable = 1'b0;
		cyc(6);
		chk(gate_drive, 8'h00);
		enable = 1'b1;
		cyc(6);
		chk(gate_drive, 8'h02);
		logic_supply_uv = 1'b1;
		cyc(6);
		chk(gate_drive, 8'h00);
		chk(fault_status_register, 8'h00);
		logic_supply_uv = 1'b0;
		open_load_threshold = 8'h7f;
		cyc(F + 6);
		chk(fault_status_register, 8'h80);
		give_verdict;
	end
endmodule
bind load_fault_monitor lfm_chk c_u (.*);
